// ### rtl/rtc_core.sv
/*
 * RTC core: serial register slave, time and calendar counters, read
 * snapshot, alarms and the interrupt / 1 Hz wave pin.
 * Assumes an open-drain serial bus outside and a 32 kHz oscillator
 * input; both are sampled by clk_sys_i.
 */
// Overview of operation
// - Time and calendar registers hold packed BCD, tens high, units low.
// - Hours bit 6 high selects 12-hour counting, low selects 24-hour.
// - In 12-hour mode bit 5 is PM, hours count 1 to 12.
// - In 24-hour mode bit 5 is the twenty digit, hours 00 to 23.
// - Month bit 7 century flag toggles when year rolls 99 to 00.
// - Weekday advances at midnight, cycling 1 to 7.
// - Register pointer wraps from 12h back to 00h.
// - START or wrap to 00h copies running time into the read buffer.
// - Writing seconds resets the sub-second divider.
// - Written bytes commit when the device drives their acknowledge.
// - 1 Hz wave rises 500 ms after the seconds write commits.
// - Date rolls at each month end with leap-year February.
// - Interrupt-control bit picks alarm interrupt or wave on the pin.
// - Alarm match per second sets flag; pin needs enable and control.
`default_nettype none

module rtc_core
  import rtc_pkg::*;
#(
  parameter int OSC_HZ = 32768,
  // Arbitrary bus address value
  parameter logic [6:0] DEV_ADDR = 7'h3A
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Oscillator
  input wire logic osc_32k_i,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b_o,
  // Interrupt or wave pin
  output logic irq_or_wave_pin_o,
  output logic irq_or_wave_pin_oe_b_o
);

  localparam int DIV_W = $clog2(OSC_HZ);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_HZ - 1);
  localparam logic [DIV_W-1:0] WAVE_RISE =
    DIV_W'(OSC_HZ * WAVE_DELAY_MS / MS_PER_SECOND);

  if (OSC_HZ < 4 || OSC_HZ % 2 != 0) begin : g_check
    $error("OSC_HZ must be even and at least 4");
  end

  typedef struct packed {
    rtc_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [4:0] ptr;
    logic sda_drv;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [TIME_COUNT-1:0][7:0] snap;
    logic [DIV_W-1:0] div;
    logic wave;
  } rtc_core_t;

  rtc_core_t core_reg;
  rtc_core_t core_next;

  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;
  logic osc_rise;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  rtc_sync_edge u_scl (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(scl_i),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );

  rtc_sync_edge u_sda (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(sda_i),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );

  rtc_sync_edge u_osc (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(osc_32k_i),
    .level_o(),
    .rise_o(osc_rise),
    .fall_o()
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [4:0] ptr_step(input logic [4:0] p);
    return (p >= REG_LAST) ? REG_SECONDS_COUNT : p + 5'h01;
  endfunction : ptr_step

  // Time bytes come from the snapshot so a burst read is coherent
  function automatic logic [7:0] read_byte(input rtc_core_t s,
                                           input logic [4:0] p);
    if (p < REG_LAST + 5'h01 && p < 5'(TIME_COUNT)) begin
      return s.snap[p[2:0]];
    end
    return (p <= REG_LAST) ? s.regs[p] : ZERO_BYTE;
  endfunction : read_byte

  function automatic logic field_hit(input logic [7:0] al,
                                     input logic [7:0] cur);
    return al[ALARM_MASK_BIT] || (al[6:0] == cur[6:0]);
  endfunction : field_hit

  function automatic logic day_hit(input logic [7:0] al,
                                   input logic [6:0][7:0] t);
    if (al[ALARM_MASK_BIT]) begin
      return 1'b1;
    end
    if (al[WEEKDAY_OR_DATE_SELECT_BIT]) begin
      return al[3:0] == t[REG_WEEKDAY_COUNT][3:0];
    end
    return al[5:0] == t[REG_DAY_OF_MONTH_COUNT][5:0];
  endfunction : day_hit

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic tick;
    logic hit1;
    logic hit2;
    logic [6:0][7:0] t;
    logic [7:0] d;
    logic [7:0] st;
    tick = 1'b0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    t = core_reg.regs[TIME_COUNT-1:0];
    d = core_reg.shreg;
    st = core_reg.regs[REG_CLOCK_STATUS];
    core_next = core_reg;

    // Sub-second divider and 1 Hz wave
    if (osc_rise) begin
      tick = (core_reg.div == DIV_LAST);
      core_next.div = tick ? '0 : core_reg.div + 1'b1;
      core_next.wave = ~tick & (core_reg.wave | (core_next.div == WAVE_RISE));
    end

    // Once-per-second update and alarm test on the new time
    if (tick) begin
      t = rtc_advance(t);
      core_next.regs[TIME_COUNT-1:0] = t;
      hit1 = field_hit(core_reg.regs[REG_FIRST_ALARM_SECONDS],
                       t[REG_SECONDS_COUNT]) &&
             field_hit(core_reg.regs[REG_FIRST_ALARM_MINUTES],
                       t[REG_MINUTES_COUNT]) &&
             field_hit(core_reg.regs[REG_FIRST_ALARM_HOURS],
                       t[REG_HOURS_COUNT]) &&
             day_hit(core_reg.regs[REG_FIRST_ALARM_DAY_OR_DATE], t);
      hit2 = (t[REG_SECONDS_COUNT] == ZERO_BYTE) &&
             field_hit(core_reg.regs[REG_SECOND_ALARM_MINUTES],
                       t[REG_MINUTES_COUNT]) &&
             field_hit(core_reg.regs[REG_SECOND_ALARM_HOURS],
                       t[REG_HOURS_COUNT]) &&
             day_hit(core_reg.regs[REG_SECOND_ALARM_DAY_OR_DATE], t);
    end

    // Serial engine
    unique case (core_reg.state)
      ST_ADDR, ST_PTR, ST_WR: begin
        if (scl_rise) begin
          core_next.shreg = {core_reg.shreg[6:0], sda_lvl};
          core_next.bitcnt = core_reg.bitcnt + 4'h1;
        end else if (scl_fall && core_reg.bitcnt == BITS_PER_BYTE) begin
          core_next.bitcnt = 4'h0;
          core_next.sda_drv = 1'b1;
          if (core_reg.state == ST_ADDR) begin
            core_next.rw = d[0];
            core_next.state = ST_ADDR_ACK;
            if (d[7:1] != DEV_ADDR) begin
              core_next.sda_drv = 1'b0;
              core_next.state = ST_WAIT;
            end
          end else if (core_reg.state == ST_PTR) begin
            core_next.ptr = (d[4:0] > REG_LAST) ? REG_SECONDS_COUNT : d[4:0];
            core_next.state = ST_PTR_ACK;
          end else begin
            // Commit at our acknowledge
            if (core_reg.ptr == REG_CLOCK_STATUS) begin
              st[OSCILLATOR_HALTED_FLAG_BIT] &= d[OSCILLATOR_HALTED_FLAG_BIT];
              st[REFERENCE_OUTPUT_ENABLE_BIT] = d[REFERENCE_OUTPUT_ENABLE_BIT];
              st[SECOND_ALARM_FLAG_BIT] &= d[SECOND_ALARM_FLAG_BIT];
              st[FIRST_ALARM_FLAG_BIT] &= d[FIRST_ALARM_FLAG_BIT];
            end else begin
              core_next.regs[core_reg.ptr] = d & WRITE_MASK[core_reg.ptr];
            end
            if (core_reg.ptr == REG_SECONDS_COUNT) begin
              core_next.div = '0;
              core_next.wave = 1'b0;
            end
            core_next.ptr = ptr_step(core_reg.ptr);
            if (core_next.ptr == REG_SECONDS_COUNT) begin
              core_next.snap = core_next.regs[TIME_COUNT-1:0];
            end
            core_next.state = ST_WR_ACK;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          core_next.shreg = read_byte(core_reg, core_reg.ptr);
          core_next.sda_drv = core_reg.rw & ~core_next.shreg[7];
          core_next.state = core_reg.rw ? ST_RD : ST_PTR;
          core_next.bitcnt = core_reg.rw ? 4'h1 : 4'h0;
        end
      end
      ST_PTR_ACK, ST_WR_ACK: begin
        if (scl_fall) begin
          core_next.sda_drv = 1'b0;
          core_next.state = ST_WR;
        end
      end
      ST_RD: begin
        if (scl_fall) begin
          if (core_reg.bitcnt == BITS_PER_BYTE) begin
            core_next.sda_drv = 1'b0;
            core_next.ptr = ptr_step(core_reg.ptr);
            if (core_next.ptr == REG_SECONDS_COUNT) begin
              core_next.snap = core_next.regs[TIME_COUNT-1:0];
            end
            core_next.state = ST_RD_ACK;
          end else begin
            core_next.shreg = {core_reg.shreg[6:0], 1'b0};
            core_next.sda_drv = ~core_reg.shreg[6];
            core_next.bitcnt = core_reg.bitcnt + 4'h1;
          end
        end
      end
      ST_RD_ACK: begin
        if (scl_rise && sda_lvl) begin
          core_next.state = ST_WAIT;
        end else if (scl_fall) begin
          core_next.shreg = read_byte(core_next, core_reg.ptr);
          core_next.sda_drv = ~core_next.shreg[7];
          core_next.bitcnt = 4'h1;
          core_next.state = ST_RD;
        end
      end
      ST_IDLE, ST_WAIT: begin
      end
      default: begin
        core_next.state = ST_IDLE;
      end
    endcase

    // Flags: a set in the same cycle as a clear wins
    st[FIRST_ALARM_FLAG_BIT] |= hit1;
    st[SECOND_ALARM_FLAG_BIT] |= hit2;
    core_next.regs[REG_CLOCK_STATUS] = st;

    // START and STOP override any state; START also resyncs the bus
    if (scl_lvl && sda_fall) begin
      core_next.state = ST_ADDR;
      core_next.bitcnt = 4'h0;
      core_next.sda_drv = 1'b0;
      core_next.snap = core_next.regs[TIME_COUNT-1:0];
    end else if (scl_lvl && sda_rise) begin
      core_next.state = ST_IDLE;
      core_next.sda_drv = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      core_reg <= '0;
      core_reg.state <= ST_IDLE;
      core_reg.regs[TIME_COUNT-1:0] <= TIME_RESET;
      core_reg.regs[REG_CLOCK_CONTROL] <= CONTROL_RESET;
      core_reg.regs[REG_CLOCK_STATUS] <= STATUS_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  logic [7:0] ctl;
  logic [7:0] sts;
  logic irq_active;
  logic wave_on;

  assign ctl = core_reg.regs[REG_CLOCK_CONTROL];
  assign sts = core_reg.regs[REG_CLOCK_STATUS];
  assign irq_active =
    (sts[FIRST_ALARM_FLAG_BIT] & ctl[FIRST_ALARM_IRQ_ENABLE_BIT]) |
    (sts[SECOND_ALARM_FLAG_BIT] & ctl[SECOND_ALARM_IRQ_ENABLE_BIT]);
  // Only the 1 Hz rate is produced; other rates leave the pin released
  assign wave_on = ~ctl[WAVE_RATE_SELECT_HIGH_BIT] &
                   ~ctl[WAVE_RATE_SELECT_LOW_BIT];

  assign sda_o = 1'b0;
  assign sda_oe_b_o = ~core_reg.sda_drv;
  assign irq_or_wave_pin_o = 1'b0;
  assign irq_or_wave_pin_oe_b_o =
    ctl[INTERRUPT_CONTROL_SELECT_BIT] ? ~irq_active
                                      : (~wave_on | core_reg.wave);

endmodule : rtc_core

`default_nettype wire

// ### rtl/rtc_pkg.sv
/*
 * Package of the RTC core: register map, bit positions, reset values,
 * serial engine states and the BCD calendar helpers.
 * Assumes all registers are 8 bits wide and addressed 00h to 12h.
 */
`default_nettype none

package rtc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int REG_COUNT = 19;
  localparam int TIME_COUNT = 7;
  localparam logic [4:0] REG_SECONDS_COUNT = 5'h00;
  localparam logic [4:0] REG_MINUTES_COUNT = 5'h01;
  localparam logic [4:0] REG_HOURS_COUNT = 5'h02;
  localparam logic [4:0] REG_WEEKDAY_COUNT = 5'h03;
  localparam logic [4:0] REG_DAY_OF_MONTH_COUNT = 5'h04;
  localparam logic [4:0] REG_MONTH_AND_CENTURY = 5'h05;
  localparam logic [4:0] REG_YEAR_COUNT = 5'h06;
  localparam logic [4:0] REG_FIRST_ALARM_SECONDS = 5'h07;
  localparam logic [4:0] REG_FIRST_ALARM_MINUTES = 5'h08;
  localparam logic [4:0] REG_FIRST_ALARM_HOURS = 5'h09;
  localparam logic [4:0] REG_FIRST_ALARM_DAY_OR_DATE = 5'h0A;
  localparam logic [4:0] REG_SECOND_ALARM_MINUTES = 5'h0B;
  localparam logic [4:0] REG_SECOND_ALARM_HOURS = 5'h0C;
  localparam logic [4:0] REG_SECOND_ALARM_DAY_OR_DATE = 5'h0D;
  localparam logic [4:0] REG_CLOCK_CONTROL = 5'h0E;
  localparam logic [4:0] REG_CLOCK_STATUS = 5'h0F;
  localparam logic [4:0] REG_CRYSTAL_AGING_TRIM = 5'h10;
  localparam logic [4:0] REG_LAST = 5'h12;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int HOUR_MODE_BIT = 6;
  localparam int MERIDIEM_FLAG_BIT = 5;
  localparam int CENTURY_BIT = 7;
  localparam int ALARM_MASK_BIT = 7;
  localparam int WEEKDAY_OR_DATE_SELECT_BIT = 6;
  localparam int INTERRUPT_CONTROL_SELECT_BIT = 2;
  localparam int WAVE_RATE_SELECT_HIGH_BIT = 4;
  localparam int WAVE_RATE_SELECT_LOW_BIT = 3;
  localparam int SECOND_ALARM_IRQ_ENABLE_BIT = 1;
  localparam int FIRST_ALARM_IRQ_ENABLE_BIT = 0;
  localparam int OSCILLATOR_HALTED_FLAG_BIT = 7;
  localparam int REFERENCE_OUTPUT_ENABLE_BIT = 3;
  localparam int SECOND_ALARM_FLAG_BIT = 1;
  localparam int FIRST_ALARM_FLAG_BIT = 0;

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [6:0][7:0] TIME_RESET = {
    8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [REG_COUNT-1:0][7:0] WRITE_MASK = {
    8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h9F, 8'h3F, 8'h07, 8'h7F, 8'h7F, 8'h7F};

  // ****************************************************************
  // BCD limits and timing
  // ****************************************************************
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [6:0] MAX_MIN_SEC = 7'h59;
  localparam logic [5:0] MAX_HOUR_24 = 6'h23;
  localparam logic [4:0] HOUR_12 = 5'h12;
  localparam logic [4:0] HOUR_11 = 5'h11;
  localparam logic [2:0] MAX_WEEKDAY = 3'h7;
  localparam logic [4:0] MAX_MONTH = 5'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam int WAVE_DELAY_MS = 500;
  localparam int MS_PER_SECOND = 1000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_WAIT
  } rtc_state_t;

  // ****************************************************************
  // Calendar helpers
  // ****************************************************************
  function automatic logic [7:0] rtc_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : rtc_bcd_inc

  // Year 00 counts as leap, which holds up to 2100
  function automatic logic [5:0] rtc_month_days(input logic [4:0] mon,
                                                input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    unique case (mon)
      5'h02: return leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default: return 6'h31;
    endcase
  endfunction : rtc_month_days

  function automatic logic [6:0][7:0] rtc_advance(
      input logic [6:0][7:0] t);
    logic [6:0][7:0] n;
    logic c;
    n = t;
    c = (t[0][6:0] == MAX_MIN_SEC);
    n[0] = c ? ZERO_BYTE : rtc_bcd_inc(t[0]);
    if (c) begin
      c = (t[1][6:0] == MAX_MIN_SEC);
      n[1] = c ? ZERO_BYTE : rtc_bcd_inc(t[1]);
    end
    if (c) begin
      if (t[2][HOUR_MODE_BIT]) begin
        c = 1'b0;
        if (t[2][4:0] == HOUR_12) begin
          n[2] = {t[2][7:5], BCD_ONE[4:0]};
        end else if (t[2][4:0] == HOUR_11) begin
          c = t[2][MERIDIEM_FLAG_BIT];
          n[2] = {t[2][7:6], ~t[2][MERIDIEM_FLAG_BIT], HOUR_12};
        end else begin
          n[2] = rtc_bcd_inc(t[2]);
        end
      end else begin
        c = (t[2][5:0] == MAX_HOUR_24);
        n[2] = c ? {t[2][7:6], 6'h00} : rtc_bcd_inc(t[2]);
      end
    end
    if (c) begin
      n[3] = (t[3][2:0] == MAX_WEEKDAY) ? BCD_ONE
                                        : rtc_bcd_inc(t[3]);
      c = (t[4][5:0] == rtc_month_days(t[5][4:0], t[6]));
      n[4] = c ? BCD_ONE : rtc_bcd_inc(t[4]);
    end
    if (c) begin
      c = (t[5][4:0] == MAX_MONTH);
      n[5] = c ? {t[5][CENTURY_BIT], BCD_ONE[6:0]} : rtc_bcd_inc(t[5]);
    end
    if (c) begin
      c = (t[6] == MAX_YEAR);
      n[6] = c ? ZERO_BYTE : rtc_bcd_inc(t[6]);
      n[5][CENTURY_BIT] = n[5][CENTURY_BIT] ^ c;
    end
    return n;
  endfunction : rtc_advance

endpackage : rtc_pkg

`default_nettype wire

// ### rtl/rtc_sync_edge.sv
/*
 * Two-stage synchroniser with edge detection for one pin.
 * Assumes the input is asynchronous to clk_sys_i.
 */
`default_nettype none

module rtc_sync_edge (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Pin and results
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } rtc_sync_t;

  rtc_sync_t sync_reg;
  rtc_sync_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = pin_i;
    sync_next.sync = sync_reg.meta;
    sync_next.last = sync_reg.sync;
  end

  // Idle-high reset so a released line gives no false edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync_reg <= '1;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level_o = sync_reg.sync;
  assign rise_o = sync_reg.sync & ~sync_reg.last;
  assign fall_o = ~sync_reg.sync & sync_reg.last;

endmodule : rtc_sync_edge

`default_nettype wire

// ### test/rtc_core_monitor.sv
/* Checker of the rtc_core pins: data line timing and pin causes.
   Assumes it is bound to rtc_core and sees only its ports. */
`default_nettype none
module rtc_mon (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Pins
  input wire logic osc_32k_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_b_o,
  input wire logic irq_or_wave_pin_o,
  input wire logic irq_or_wave_pin_oe_b_o
);
  // ****
  // Ages since the last bus clock fall or oscillator rise
  // ****
  logic scl_last_reg, osc_last_reg;
  logic [3:0] scl_age_reg, evt_age_reg;
  logic scl_fell, osc_rose;
  assign scl_fell = scl_last_reg && !scl_i;
  assign osc_rose = !osc_last_reg && osc_32k_i;
  always_ff @(posedge clk_sys_i) begin
    scl_last_reg <= scl_i;
    osc_last_reg <= osc_32k_i;
    if (scl_fell) scl_age_reg <= 4'h0;
    else if (scl_age_reg != 4'hF) scl_age_reg <= scl_age_reg + 4'h1;
    if (scl_fell || osc_rose) evt_age_reg <= 4'h0;
    else if (evt_age_reg != 4'hF) evt_age_reg <= evt_age_reg + 4'h1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_scl_high;
    ##[1:60] $rose(scl_i) ##1 scl_i [*3];
  endsequence
  AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  AST_PIN_OPEN_DRAIN: assert property (irq_or_wave_pin_o == 1'b0)
    else $error("event pin driven high");
  AST_RESET_SDA: assert property ($rose(rst_b_i) |-> sda_oe_b_o)
    else $error("data line held after reset");
  AST_RESET_PIN: assert property ($rose(rst_b_i) |-> irq_or_wave_pin_oe_b_o)
    else $error("event pin low after reset");
  AST_SDA_STILL_SCL_HIGH: assert property (
    scl_i [*6] |-> $stable(sda_oe_b_o))
    else $error("data moved while bus clock high");
  AST_SDA_AFTER_FALL: assert property (
    !$stable(sda_oe_b_o) |-> scl_age_reg < 4'hC)
    else $error("data moved without a bus clock fall");
  AST_ACK_HOLD: assert property (
    $fell(sda_oe_b_o) |-> !sda_oe_b_o throughout s_scl_high)
    else $error("driven low bit not held over clock high");
  AST_PIN_CAUSE: assert property (
    !$stable(irq_or_wave_pin_oe_b_o) |-> evt_age_reg < 4'hC)
    else $error("event pin moved without a cause");
endmodule : rtc_mon
bind rtc_core rtc_mon rtc_mon_inst (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .osc_32k_i(osc_32k_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
  .irq_or_wave_pin_o(irq_or_wave_pin_o),
  .irq_or_wave_pin_oe_b_o(irq_or_wave_pin_oe_b_o));
`default_nettype wire

// ### test/rtc_bus_master.sv
/* Serial bus master model: start, stop, byte out and byte in.
   Assumes the bench resolves the data line with a pull-up. */
`default_nettype none
module rtc_bus_master (
  // Clock
  input wire logic clk_sys_i,
  // Bus
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // ****
  // Bus phases, 160 ns per bit, moved on falling clock edges
  // ****
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : hold
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    hold(10);
    scl_o = 1'b1;
    hold(10);
    r = sda_i;
    hold(10);
    scl_o = 1'b0;
    hold(10);
  endtask : bit_io
  task automatic start();
    logic r;
    for (int i = 0; i < 9 && sda_i !== 1'b1; i++) begin
      bit_io(1'b1, r);
    end
    sda_o = 1'b1;
    hold(10);
    scl_o = 1'b1;
    hold(10);
    sda_o = 1'b0;
    hold(10);
    scl_o = 1'b0;
    hold(10);
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    hold(10);
    scl_o = 1'b1;
    hold(10);
    sda_o = 1'b1;
    hold(10);
  endtask : stop
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask : byte_out
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : byte_in
endmodule : rtc_bus_master
`default_nettype wire

// ### test/rtc_core_bench.sv
/* Self-checking bench of rtc_core: register map, calendar carries,
   wave timing and alarm pin through the bus master model.
   Assumes the checker binds itself to rtc_core. */
`default_nettype none
module rtc_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OSC = 8;
  localparam logic [6:0] ADDR = 7'h2C; // Arbitrary bus address
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic osc_32k_i = 1'b0;
  logic scl, sda_m, sda_o, sda_oe_b_o, pin_o, pin_oe_b;
  wire logic sda = sda_m & (sda_oe_b_o | sda_o);
  int err_total = 0;
  int compares = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  rtc_core #(.OSC_HZ(OSC), .DEV_ADDR(ADDR)) rtc_core_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .osc_32k_i(osc_32k_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
    .irq_or_wave_pin_o(pin_o), .irq_or_wave_pin_oe_b_o(pin_oe_b));
  rtc_bus_master rtc_bus_master_inst (.clk_sys_i(clk_sys_i),
    .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Oscillator only runs when asked, so set values stay put
  task automatic osc(input int n);
    repeat (n) begin
      osc_32k_i = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      osc_32k_i = 1'b0;
      repeat (10) @(negedge clk_sys_i);
    end
  endtask : osc
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic a;
    rtc_bus_master_inst.start();
    rtc_bus_master_inst.byte_out({ADDR, 1'b0}, a);
    chk({7'h0, a}, 8'h00);
    rtc_bus_master_inst.byte_out(p, a);
    foreach (d[i]) begin
      rtc_bus_master_inst.byte_out(d[i], a);
      chk({7'h0, a}, 8'h00);
    end
    rtc_bus_master_inst.stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
    logic a;
    logic [7:0] v;
    rtc_bus_master_inst.start();
    rtc_bus_master_inst.byte_out({ADDR, 1'b0}, a);
    rtc_bus_master_inst.byte_out(p, a);
    rtc_bus_master_inst.start();
    rtc_bus_master_inst.byte_out({ADDR, 1'b1}, a);
    foreach (e[i]) begin
      rtc_bus_master_inst.byte_in(i == e.size() - 1, v);
      chk(v, e[i]);
    end
    rtc_bus_master_inst.stop();
  endtask : rd
  task automatic roll(input logic [7:0] s[$], input logic [7:0] e[$]);
    wr(8'h00, s);
    osc(OSC);
    rd(8'h00, e);
  endtask : roll
  // ****
  // Scenarios
  // ****
  task automatic t_reset_map();
    rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h80, 8'h00,
      8'h00, 8'h00});
  endtask : t_reset_map
  // Foreign address: no acknowledge, rest of the transfer ignored
  task automatic t_refuse();
    logic a;
    rtc_bus_master_inst.start();
    rtc_bus_master_inst.byte_out({~ADDR, 1'b0}, a);
    chk({7'h0, a}, 8'h01);
    rtc_bus_master_inst.byte_out(8'h00, a);
    chk({7'h0, a}, 8'h01);
    rtc_bus_master_inst.stop();
  endtask : t_refuse
  task automatic t_calendar();
    roll('{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99},
      '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00});
    roll('{8'h59, 8'h59, 8'h71, 8'h03, 8'h28, 8'h02, 8'h24},
      '{8'h00, 8'h00, 8'h52, 8'h04, 8'h29, 8'h02, 8'h24});
    roll('{8'h59, 8'h59, 8'h23, 8'h05, 8'h28, 8'h02, 8'h23},
      '{8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h03, 8'h23});
  endtask : t_calendar
  task automatic t_wave();
    wr(8'h0E, '{8'h00});
    osc(OSC / 4);
    wr(8'h00, '{8'h30});
    chk({7'h0, pin_oe_b}, 8'h00);
    osc(OSC / 2 - 1);
    chk({7'h0, pin_oe_b}, 8'h00);
    osc(1);
    chk({7'h0, pin_oe_b}, 8'h01);
    osc(OSC / 2);
    chk({7'h0, pin_oe_b}, 8'h00);
    rd(8'h12, '{8'h00, 8'h31, 8'h00});
  endtask : t_wave
  task automatic t_alarm();
    wr(8'h07, '{8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00,
      8'h05});
    chk({7'h0, pin_oe_b}, 8'h01);
    osc(OSC);
    chk({7'h0, pin_oe_b}, 8'h00);
    rd(8'h0F, '{8'h81});
    wr(8'h0E, '{8'h04});
    chk({7'h0, pin_oe_b}, 8'h01);
  endtask : t_alarm
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_reset_map();
    t_refuse();
    t_calendar();
    t_wave();
    t_alarm();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_total++;
    finish_test();
  end
endmodule : rtc_core_bench
`default_nettype wire
